// *** scis_params.svh ***
// Constants for the supply control serial slave
`ifndef SCIS_PARAMS_SVH
`define SCIS_PARAMS_SVH
`define SCIS_ADDR_BASE   7'h08
`define SCIS_REG_RESET   8'h00
`define SCIS_CTRL_RESET  6'h00
`define SCIS_CTRL_MSB    7
`define SCIS_CTRL_LSB    2
`define SCIS_BITS_BYTE   4'h8
`define SCIS_SYNC_W      10
`endif

// *** scis_pkg.sv ***
// Types for the supply control serial slave
package scis_pkg;
   typedef struct packed {
      logic current_limit_style;
      logic tx_output_select;
      logic tone_force;
      logic line_drop_boost;
      logic voltage_choice;
      logic power_on_ctrl;
   } scis_ctrl_s;
   typedef struct packed {
      logic       rx_supply_out;
      logic       tx_supply_out;
      logic [1:0] level_sel;
      logic       tone_on;
      logic       tx_tone_out;
      logic       pulsed_limit;
      logic       static_limit;
   } scis_power_s;
   typedef enum logic [2:0] {
      SCIS_IDLE, SCIS_ADDR, SCIS_ADDR_ACK, SCIS_WR_DATA, SCIS_WR_ACK, SCIS_RD_DATA, SCIS_RD_ACK
   } scis_state_e;
endpackage

// *** scis_supply_ctrl.sv ***
// Serial slave, control/status register and power block steering for one section
`timescale 1ns/1ns
`default_nettype none
`include "scis_params.svh"
module scis_supply_ctrl (
   // Clock and reset
   input  wire logic            ref_clk,
   input  wire logic            resetn,
   // Serial bus, open drain data
   input  wire logic            scl_in,
   input  wire logic            sda_in,
   output var  logic            sda_out,
   output var  logic            sda_oe,
   // Address strap level, digitised low to high
   input  wire logic [1:0]      addr_strap,
   // Supply lockout comparators
   input  wire logic            supply_above_upper,
   input  wire logic            supply_below_lower,
   // Tone pins and protection inputs
   input  wire logic            tone_gate_in,
   input  wire logic            tone_sense_in,
   input  wire logic            thermal_trip,
   input  wire logic            overload_trip,
   // Register view and power block controls
   output var  scis_pkg::scis_ctrl_s  ctrl,
   output var  logic            thermal_flag,
   output var  logic            overload_flag,
   output var  logic            tone_detect_out,
   output var  scis_pkg::scis_power_s power
);
   import scis_pkg::*;

   // Every pin goes through two flops before use
   logic [`SCIS_SYNC_W-1:0] sync1_q;
   logic [`SCIS_SYNC_W-1:0] sync2_q;
   logic                    scl_prev_q;
   logic                    sda_prev_q;
   logic                    scl_s;
   logic                    sda_s;
   logic                    scl_rise;
   logic                    scl_fall;
   logic                    start_det;
   logic                    stop_det;
   logic [1:0]              strap_s;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         // Bus pins idle high on their pull-ups, so no false edge follows reset
         sync1_q    <= {{(`SCIS_SYNC_W-2){1'b0}}, 2'b11};
         sync2_q    <= {{(`SCIS_SYNC_W-2){1'b0}}, 2'b11};
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         sync1_q    <= {addr_strap, supply_below_lower, supply_above_upper, overload_trip,
                        thermal_trip, tone_sense_in, tone_gate_in, sda_in, scl_in};
         sync2_q    <= sync1_q;
         scl_prev_q <= sync2_q[0];
         sda_prev_q <= sync2_q[1];
      end
   end

   assign scl_s     = sync2_q[0];
   assign sda_s     = sync2_q[1];
   assign strap_s   = sync2_q[9:8];
   assign scl_rise  = scl_s & ~scl_prev_q;
   assign scl_fall  = ~scl_s & scl_prev_q;
   // Data may only move while the clock is low; a move while high frames a transfer
   assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // Lockout with hysteresis
   logic supply_ok_q;
   logic supply_ok_d;

   always_comb begin
      if (supply_ok_q) begin
         supply_ok_d = ~sync2_q[7];
      end else begin
         supply_ok_d = sync2_q[6];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         supply_ok_q <= 1'b0;
      end else begin
         supply_ok_q <= supply_ok_d;
      end
   end

   // Slave state
   scis_state_e state_q;
   scis_state_e state_d;
   logic [3:0]  cnt_q;
   logic [3:0]  cnt_d;
   logic [7:0]  shift_q;
   logic [7:0]  shift_d;
   logic        rw_q;
   logic        rw_d;
   logic        mack_q;
   logic        mack_d;
   logic        oe_q;
   logic        oe_d;
   scis_ctrl_s  ctrl_q;
   scis_ctrl_s  ctrl_d;
   logic [6:0]  my_addr;
   logic [7:0]  rd_byte;
   logic        addr_hit;

   assign my_addr  = `SCIS_ADDR_BASE | {5'h00, strap_s};
   assign addr_hit = (shift_q[7:1] == my_addr);
   assign rd_byte  = {ctrl_q, thermal_flag, overload_flag};

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      rw_d    = rw_q;
      mack_d  = mack_q;
      oe_d    = oe_q;
      ctrl_d  = ctrl_q;
      if (!supply_ok_q) begin
         // Deaf on the bus and cleared while the supply is low
         state_d = SCIS_IDLE;
         cnt_d   = 4'h0;
         oe_d    = 1'b0;
         ctrl_d  = scis_ctrl_s'(`SCIS_CTRL_RESET);
      end else if (stop_det) begin
         state_d = SCIS_IDLE;
         oe_d    = 1'b0;
      end else if (start_det) begin
         state_d = SCIS_ADDR;
         cnt_d   = 4'h0;
         oe_d    = 1'b0;
      end else begin
         case (state_q)
            SCIS_ADDR: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_s};
                  cnt_d   = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == `SCIS_BITS_BYTE) begin
                  if (addr_hit) begin
                     rw_d    = shift_q[0];
                     oe_d    = 1'b1;
                     state_d = SCIS_ADDR_ACK;
                  end else begin
                     state_d = SCIS_IDLE;
                  end
               end
            end
            SCIS_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (rw_q) begin
                     shift_d = rd_byte;
                     oe_d    = ~rd_byte[7];
                     state_d = SCIS_RD_DATA;
                  end else begin
                     oe_d    = 1'b0;
                     state_d = SCIS_WR_DATA;
                  end
               end
            end
            SCIS_WR_DATA: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_s};
                  cnt_d   = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == `SCIS_BITS_BYTE) begin
                  // Flag bits of the byte are dropped
                  ctrl_d  = scis_ctrl_s'(shift_q[`SCIS_CTRL_MSB:`SCIS_CTRL_LSB]);
                  oe_d    = 1'b1;
                  state_d = SCIS_WR_ACK;
               end
            end
            SCIS_WR_ACK: begin
               if (scl_fall) begin
                  oe_d    = 1'b0;
                  cnt_d   = 4'h0;
                  state_d = SCIS_WR_DATA;
               end
            end
            SCIS_RD_DATA: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == `SCIS_BITS_BYTE) begin
                     oe_d    = 1'b0;
                     state_d = SCIS_RD_ACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d    = ~shift_q[6];
                  end
               end
            end
            SCIS_RD_ACK: begin
               if (scl_rise) begin
                  mack_d = ~sda_s;
               end else if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (mack_q) begin
                     shift_d = rd_byte;
                     oe_d    = ~rd_byte[7];
                     state_d = SCIS_RD_DATA;
                  end else begin
                     state_d = SCIS_IDLE;
                  end
               end
            end
            default: begin
               state_d = state_q;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= SCIS_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         rw_q    <= 1'b0;
         mack_q  <= 1'b0;
         oe_q    <= 1'b0;
         ctrl_q  <= scis_ctrl_s'(`SCIS_CTRL_RESET);
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         rw_q    <= rw_d;
         mack_q  <= mack_d;
         oe_q    <= oe_d;
         ctrl_q  <= ctrl_d;
      end
   end

   // Output group, all registered
   scis_power_s power_d;
   logic        tone_gate;

   // Host firmware keys the tone and reads the detector directly on these pins
   assign tone_gate = ctrl_q.tone_force | sync2_q[2];

   always_comb begin
      power_d              = '0;
      power_d.pulsed_limit = ~ctrl_q.current_limit_style;
      power_d.static_limit = ctrl_q.current_limit_style;
      if (ctrl_q.power_on_ctrl) begin
         power_d.level_sel     = {ctrl_q.line_drop_boost, ctrl_q.voltage_choice};
         power_d.rx_supply_out = ~ctrl_q.tx_output_select;
         power_d.tx_supply_out = ctrl_q.tx_output_select;
         power_d.tone_on       = tone_gate;
         power_d.tx_tone_out   = ctrl_q.tx_output_select & tone_gate;
      end else begin
         power_d.pulsed_limit = 1'b0;
         power_d.static_limit = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         power           <= '0;
         ctrl            <= '0;
         thermal_flag    <= 1'b0;
         overload_flag   <= 1'b0;
         tone_detect_out <= 1'b0;
         sda_out         <= 1'b0;
         sda_oe          <= 1'b0;
      end else begin
         power           <= power_d;
         ctrl            <= ctrl_d;
         thermal_flag    <= sync2_q[4];
         overload_flag   <= sync2_q[5];
         tone_detect_out <= sync2_q[3];
         sda_out         <= 1'b0;
         sda_oe          <= oe_d;
      end
   end

   a_uvlo_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
      !supply_ok_q |=> (ctrl_q == scis_ctrl_s'(`SCIS_CTRL_RESET)) && !sda_oe)
      else $error("register not held clear under lockout");
   a_addr_ack: assert property (@(posedge ref_clk) disable iff (!resetn)
      supply_ok_q && !start_det && !stop_det && state_q == SCIS_ADDR && scl_fall
      && cnt_q == 4'h8 && addr_hit |=> sda_oe && state_q == SCIS_ADDR_ACK)
      else $error("matching address not acknowledged");
   a_addr_miss: assert property (@(posedge ref_clk) disable iff (!resetn)
      state_q == SCIS_ADDR && scl_fall && cnt_q == 4'h8 && !addr_hit |=> !sda_oe)
      else $error("foreign address acknowledged");
   a_write_update: assert property (@(posedge ref_clk) disable iff (!resetn)
      supply_ok_q && !start_det && !stop_det && state_q == SCIS_WR_DATA && scl_fall
      && cnt_q == 4'h8 |=> ctrl_q == scis_ctrl_s'($past(shift_q[7:2])) && sda_oe)
      else $error("write byte not stored");
   a_power_off: assert property (@(posedge ref_clk) disable iff (!resetn)
      !ctrl_q.power_on_ctrl |=> !power.rx_supply_out && !power.tx_supply_out && !power.tone_on)
      else $error("power block on while disabled");
   a_tone_forced: assert property (@(posedge ref_clk) disable iff (!resetn)
      ctrl_q.power_on_ctrl && ctrl_q.tone_force |=> power.tone_on)
      else $error("forced tone missing");
   a_limit_style: assert property (@(posedge ref_clk) disable iff (!resetn)
      ctrl_q.power_on_ctrl |=> power.static_limit == $past(ctrl_q.current_limit_style)
      && power.pulsed_limit != power.static_limit)
      else $error("limit style wrong");
   a_read_msb: assert property (@(posedge ref_clk) disable iff (!resetn)
      supply_ok_q && !start_det && !stop_det && state_q == SCIS_ADDR_ACK && scl_fall
      && rw_q |=> sda_oe == !$past(rd_byte[7]))
      else $error("read MSB not driven");
   a_level_sel: assert property (@(posedge ref_clk) disable iff (!resetn)
      ctrl_q.power_on_ctrl |=> power.level_sel
      == $past({ctrl_q.line_drop_boost, ctrl_q.voltage_choice}))
      else $error("level select wrong");
endmodule
`default_nettype wire

// *** scis_master_model.sv ***
// Host side bus master model that clocks the serial bus
`timescale 1ns/1ns
`default_nettype none
module scis_master_model (
   // Serial bus, data released means pulled up
   output var  logic scl,
   output var  logic sda_drv,
   input  wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Data moves only while scl is low; sampled in mid high phase
   task automatic bit_cyc(input logic b, output logic s);
      #200 sda_drv = b;
      #200 scl = 1'b1;
      #200 s = sda;
      #200 scl = 1'b0;
   endtask
   task automatic start();
      #200 sda_drv = 1'b1;
      #200 scl = 1'b1;
      #400 sda_drv = 1'b0;
      #400 scl = 1'b0;
   endtask
   // Clock stays high after stop, as the pull-up leaves it
   task automatic stop();
      #200 sda_drv = 1'b0;
      #200 scl = 1'b1;
      #400 sda_drv = 1'b1;
      #400;
   endtask
   // Byte out MSB first, returns the line level on the ninth clock
   task automatic put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
      bit_cyc(1'b1, ack);
   endtask
   // Byte in, then ack to ask for more or leave high to end
   task automatic get(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b1, s);
         d[i] = s;
      end
      bit_cyc(~more, s);
   endtask
endmodule
`default_nettype wire

// *** scis_supply_ctrl_bench.sv ***
// Self-checking bench for the supply control serial slave
`timescale 1ns/1ns
`default_nettype none
`include "scis_params.svh"
module scis_supply_ctrl_bench;
   import scis_pkg::*;
   logic        ref_clk = 1'b0;
   logic        resetn, scl, sda_drv, sda_out, sda_oe, above, below;
   logic        tone_gate_in, tone_sense_in, thermal_trip, overload_trip;
   logic        thermal_flag, overload_flag, tone_detect_out;
   logic [1:0]  strap;
   logic [7:0]  ref_reg = 8'h00;
   logic [7:0]  exp_q[$];
   scis_ctrl_s  ctrl;
   scis_power_s power;
   int          num_errors = 0;
   int          checks_done = 0;
   integer      seed = 57639;
   // Open drain wire with pull-up
   wire sda = sda_drv & ~(sda_oe & ~sda_out);

   scis_supply_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(strap), .supply_above_upper(above),
      .supply_below_lower(below), .tone_gate_in(tone_gate_in), .tone_sense_in(tone_sense_in),
      .thermal_trip(thermal_trip), .overload_trip(overload_trip), .ctrl(ctrl),
      .thermal_flag(thermal_flag), .overload_flag(overload_flag),
      .tone_detect_out(tone_detect_out), .power(power));
   scis_master_model m (.scl(scl), .sda_drv(sda_drv), .sda(sda));

   always #50 ref_clk = ~ref_clk;

   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_ack(input logic g, input logic e);
      cmp({7'h00, g}, {7'h00, e});
   endtask
   task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
      cmp(g, e);
   endtask
   task automatic chk_pwr(input logic [7:0] g, input logic [7:0] e);
      cmp(g, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   function automatic logic [7:0] exp_pwr(input logic [7:0] r, input logic g);
      logic t;
      logic [7:0] p;
      t = r[5] | g;
      p = {~r[6], r[6], r[4], r[3], t, r[6] & t, ~r[7], r[7]};
      return r[2] ? p : 8'h00;
   endfunction

   // Write n data bytes; e is the expected address ack level
   task automatic wr(input logic [6:0] a, input logic [7:0] d0, input logic [7:0] d1,
                     input int n, input logic e);
      logic ack;
      m.start();
      m.put({a, 1'b0}, ack);
      chk_ack(ack, e);
      for (int i = 0; i < n && !ack; i++) begin
         m.put(i ? d1 : d0, ack);
         chk_ack(ack, 1'b0);
      end
      m.stop();
   endtask
   task automatic rd(input int n);
      logic ack;
      logic [7:0] d;
      m.start();
      m.put({`SCIS_ADDR_BASE + {5'h00, strap}, 1'b1}, ack);
      chk_ack(ack, 1'b0);
      for (int i = 0; i < n; i++) begin
         m.get(i < n - 1, d);
         chk_reg(d, exp_q.pop_front());
      end
      m.stop();
   endtask

   task automatic results();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      logic [7:0] d, g;
      {resetn, above, below, tone_gate_in, tone_sense_in, thermal_trip, overload_trip} = 7'h10;
      strap = 2'h0;
      repeat (5) @(negedge ref_clk);
      resetn = 1'b1;
      idle(2);
      chk_reg({ctrl, thermal_flag, overload_flag}, 8'h00);
      chk_pwr(power, 8'h00);
      $display("test reset done");
      wr(`SCIS_ADDR_BASE, 8'hFC, 8'hFC, 1, 1'b1);
      chk_reg({ctrl, 2'b00}, 8'h00);
      $display("test lockout done");
      above = 1'b1;
      below = 1'b0;
      idle(10);
      // Fifth address is never valid; second byte must overwrite the first
      for (int s = 0; s < 4; s++) begin
         strap = s[1:0];
         idle(4);
         for (int a = 0; a < 5; a++) begin
            d = 8'($random(seed));
            g = 8'($random(seed));
            tone_gate_in = g[0] & ~g[5];
            if (!(g[5] | tone_gate_in)) g[6] = 1'b0;
            tone_sense_in = g[1];
            wr(`SCIS_ADDR_BASE + a[6:0], d, g, 2, a != s);
            if (a == s) ref_reg = g;
            idle(6);
            chk_reg({ctrl, 2'b00}, ref_reg & 8'hFC);
            chk_pwr(power, exp_pwr(ref_reg, tone_gate_in));
            chk_ack(tone_detect_out, tone_sense_in);
         end
      end
      $display("test writes done");
      for (int i = 0; i < 4; i++) begin
         {thermal_trip, overload_trip} = i[1:0];
         idle(6);
         repeat (2) exp_q.push_back({ref_reg[7:2], i[1:0]});
         rd(2);
      end
      $display("test reads done");
      // Dropping below the upper threshold alone must not reset
      above = 1'b0;
      idle(8);
      chk_reg({ctrl, 2'b00}, ref_reg & 8'hFC);
      below = 1'b1;
      idle(8);
      chk_reg({ctrl, 2'b00}, 8'h00);
      chk_pwr(power, 8'h00);
      wr(`SCIS_ADDR_BASE + {5'h00, strap}, 8'hFC, 8'hFC, 1, 1'b1);
      idle(4);
      chk_reg({ctrl, 2'b00}, 8'h00);
      $display("test hysteresis done");
      results();
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
